// ===== rtl/dtps_pkg.sv
// Constants shared by the DMA and timer pin select block.
package dtps_pkg;

   // Width of the flat pin vector: port p, bit b sits at index p*8+b.
   localparam int unsigned PIN_W        = 56;
   localparam int unsigned PORT_BITS    = 8;

   // Register byte offsets on the AXI4-Lite bus and reset values.
   localparam logic [31:0] OFF_DMA_SEL  = 32'h0000_0000;
   localparam logic [31:0] OFF_TMR_SEL  = 32'h0000_0004;
   localparam logic [7:0]  RST_DMA_SEL  = 8'h00;
   localparam logic [7:0]  RST_TMR_SEL  = 8'h00;
   localparam int unsigned REG_W        = 8;

   // Channel c of the DMA select register holds a two-bit code at bits 2c+1:2c.
   localparam int unsigned DMA_CHANS    = 4;
   localparam int unsigned DMA_FIELD_W  = 2;
   localparam logic [1:0]  DMA_CODE_A   = 2'b00;
   localparam logic [1:0]  DMA_CODE_B   = 2'b01;

   // Order of the three control pins inside one group.
   localparam int unsigned DMA_REQ_OFS  = 0;
   localparam int unsigned DMA_ACK_OFS  = 1;
   localparam int unsigned DMA_TRANSFER_END_OFS = 2;

   // Timer select bit i controls timer pin i of the tables below.
   localparam int unsigned TMR_PINS     = 8;

   // AXI response codes.
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;

   // Index of pin Ppb in the flat pin vector.
   function automatic int unsigned pin_idx(input int unsigned port, input int unsigned pbit);
      return port * PORT_BITS + pbit;
   endfunction : pin_idx

   // Compare (and shared capture) pin per timer select bit, bit 0 first.
   localparam int unsigned TMR_CMP_PIN [8] = '{pin_idx(3, 2), pin_idx(3, 0), pin_idx(3, 4),
                                              pin_idx(3, 6), pin_idx(2, 2), pin_idx(2, 1),
                                              pin_idx(2, 5), pin_idx(2, 6)};
   // Split capture pin per timer select bit, bit 0 first.
   localparam int unsigned TMR_CAP_PIN [8] = '{pin_idx(3, 3), pin_idx(3, 1), pin_idx(3, 5),
                                              pin_idx(3, 7), pin_idx(2, 3), pin_idx(2, 0),
                                              pin_idx(2, 4), pin_idx(2, 7)};

   // First pin of each channel's group for code A (channels 0 and 1 only, per DMA_GRP_A_OK) and code B.
   localparam int unsigned DMA_GRP_A_PIN [4] = '{pin_idx(1, 0), pin_idx(1, 4), 0, 0};
   localparam logic [3:0]  DMA_GRP_A_OK      = 4'h3;
   localparam int unsigned DMA_GRP_B_PIN [4] = '{pin_idx(3, 0), pin_idx(3, 3), pin_idx(6, 0),
                                                pin_idx(6, 3)};

endpackage : dtps_pkg

// ===== rtl/dtps_sync_if.sv
// Interface carrying raw and filtered pin levels between the pin mux and its synchroniser.
interface dtps_sync_if #(parameter int unsigned W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport core (input raw, output clean);
   modport user (output raw, input clean);
endinterface : dtps_sync_if

// ===== rtl/dtps_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module dtps_sync #(
   parameter int unsigned W       = 8,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic clk_in,   // System clock.
   input wire logic rstn_in,  // Asynchronous reset, active low.
   dtps_sync_if.core bus      // Raw levels in, filtered levels out.
);

   if (W < 1) begin : g_bad_w
      $error("dtps_sync: W must be at least 1.");
   end

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] clean;
   } dtps_sync_state_t;

   dtps_sync_state_t s_reg;
   dtps_sync_state_t s_next;

   // Stage one is only ever read by stage two, so metastability cannot leak into logic.
   always_comb begin
      s_next       = s_reg;
      s_next.s1    = bus.raw;
      s_next.s2    = s_reg.s1;
      s_next.s3    = s_reg.s2;
      s_next.clean = (s_reg.s3 & ~(s_reg.s2 ^ s_reg.s3)) | (s_reg.clean & (s_reg.s2 ^ s_reg.s3));
   end

   // Pins idle high, so the chain resets high to avoid false active-low requests.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_reg <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus.clean = s_reg.clean;

endmodule : dtps_sync

// ===== rtl/dtps_pin_select.sv
// Pin multiplexer for DMA control pins and timer capture pins, with an AXI4-Lite slave.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
module dtps_pin_select
   import dtps_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic              REF_CLK_IN,        // System clock, 125 MHz.
   input  wire logic              RSTN_IN,           // Asynchronous reset, active low.
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,   // Write address.
   input  wire logic              S_AXI_AWVALID_IN,  // Write address valid.
   output logic                   S_AXI_AWREADY_OUT, // Write address ready.
   input  wire logic [31:0]       S_AXI_WDATA_IN,    // Write data.
   input  wire logic [3:0]        S_AXI_WSTRB_IN,    // Write byte strobes.
   input  wire logic              S_AXI_WVALID_IN,   // Write data valid.
   output logic                   S_AXI_WREADY_OUT,  // Write data ready.
   output logic [1:0]             S_AXI_BRESP_OUT,   // Write response.
   output logic                   S_AXI_BVALID_OUT,  // Write response valid.
   input  wire logic              S_AXI_BREADY_IN,   // Write response ready.
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,   // Read address.
   input  wire logic              S_AXI_ARVALID_IN,  // Read address valid.
   output logic                   S_AXI_ARREADY_OUT, // Read address ready.
   output logic [31:0]            S_AXI_RDATA_OUT,   // Read data.
   output logic [1:0]             S_AXI_RRESP_OUT,   // Read response.
   output logic                   S_AXI_RVALID_OUT,  // Read data valid.
   input  wire logic              S_AXI_RREADY_IN,   // Read data ready.
   input  wire logic [PIN_W-1:0]  PIN_IN,            // Pin levels from the pads.
   output logic [PIN_W-1:0]       PIN_DATA_OUT,      // Pin drive levels.
   output logic [PIN_W-1:0]       PIN_OE_OUT,        // Pin output enables, high drives.
   output logic [3:0]             DMA_REQ_N_OUT,     // Transfer requests to the controller.
   input  wire logic [3:0]        DMA_ACK_N_IN,      // Transfer acknowledges from it.
   input  wire logic [3:0]        DMA_TRANSFER_END_N_IN,     // Transfer ends from it.
   input  wire logic [7:0]        TMR_CMP_IN,        // Compare output levels per timer pin.
   input  wire logic [7:0]        TMR_CMP_OE_IN,     // Compare output enables per timer pin.
   output logic [7:0]             TMR_CAP_OUT        // Capture input levels per timer pin.
);

   if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
      $error("dtps_pin_select: ADDR_W must lie between 3 and 32.");
   end

   typedef struct packed {
      logic              aw_rdy;
      logic              w_rdy;
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] waddr;
      logic [REG_W-1:0]  wdata;
      logic              wstrb0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              ar_rdy;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [REG_W-1:0]  rdata;
      logic [REG_W-1:0]  dma_sel;
      logic [REG_W-1:0]  tmr_sel;
      logic [PIN_W-1:0]  pin_out;
      logic [PIN_W-1:0]  pin_oe;
      logic [3:0]        req_n;
      logic [7:0]        cap;
      logic              armed;
   } dtps_top_state_t;

   localparam dtps_top_state_t ST_RESET = '{
      aw_rdy: 1'b1, w_rdy: 1'b1, aw_got: 1'b0, w_got: 1'b0, waddr: '0, wdata: '0,
      wstrb0: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY, ar_rdy: 1'b1, rvalid: 1'b0,
      rresp: RESP_OKAY, rdata: '0, dma_sel: RST_DMA_SEL, tmr_sel: RST_TMR_SEL,
      pin_out: '0, pin_oe: '0, req_n: 4'hf, cap: 8'hff, armed: 1'b0};

   dtps_top_state_t s_reg;
   dtps_top_state_t s_next;

   // Pad levels are foreign to this clock, so they pass the three-stage filter.
   dtps_sync_if #(.W(PIN_W)) pin_sync ();

   assign pin_sync.raw = PIN_IN;

   dtps_sync #(
      .W       (PIN_W),
      .RST_VAL ({PIN_W{1'b1}})
   ) u_pin_sync (
      .clk_in  (REF_CLK_IN),
      .rstn_in (RSTN_IN),
      .bus     (pin_sync.core)
   );

   // Register writes, reads and pin routing all come out of one next-state function.
   always_comb begin
      logic [1:0]  code;
      logic        routed;
      int unsigned base;
      code   = 2'b00;
      routed = 1'b0;
      base   = 0;
      s_next = s_reg;
      s_next.armed = 1'b1; // Set by the first edge out of reset; only the checks read it.

      // Address and data are taken independently and in either order.
      if (s_reg.aw_rdy && S_AXI_AWVALID_IN) begin
         s_next.aw_rdy = 1'b0;
         s_next.aw_got = 1'b1;
         s_next.waddr  = S_AXI_AWADDR_IN;
      end
      if (s_reg.w_rdy && S_AXI_WVALID_IN) begin
         s_next.w_rdy  = 1'b0;
         s_next.w_got  = 1'b1;
         s_next.wdata  = S_AXI_WDATA_IN[REG_W-1:0];
         s_next.wstrb0 = S_AXI_WSTRB_IN[0];
      end

      // Commit once both halves are in; only byte lane 0 carries register bits.
      if (s_reg.aw_got && s_reg.w_got) begin
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = RESP_OKAY;
         if (s_reg.waddr[ADDR_W-1:2] == OFF_DMA_SEL[ADDR_W-1:2]) begin
            if (s_reg.wstrb0) begin
               s_next.dma_sel = s_reg.wdata;
            end
         end else if (s_reg.waddr[ADDR_W-1:2] == OFF_TMR_SEL[ADDR_W-1:2]) begin
            if (s_reg.wstrb0) begin
               s_next.tmr_sel = s_reg.wdata;
            end
         end else begin
            s_next.bresp = RESP_SLVERR;
         end
      end

      // Both write channels reopen only after the response has been taken.
      if (s_reg.bvalid && S_AXI_BREADY_IN) begin
         s_next.bvalid = 1'b0;
         s_next.aw_rdy = 1'b1;
         s_next.w_rdy  = 1'b1;
      end

      // Reads answer one cycle after the address is taken.
      if (s_reg.ar_rdy && S_AXI_ARVALID_IN) begin
         s_next.ar_rdy = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rresp  = RESP_OKAY;
         if (S_AXI_ARADDR_IN[ADDR_W-1:2] == OFF_DMA_SEL[ADDR_W-1:2]) begin
            s_next.rdata = s_reg.dma_sel;
         end else if (S_AXI_ARADDR_IN[ADDR_W-1:2] == OFF_TMR_SEL[ADDR_W-1:2]) begin
            s_next.rdata = s_reg.tmr_sel;
         end else begin
            s_next.rdata = '0;
            s_next.rresp = RESP_SLVERR;
         end
      end
      if (s_reg.rvalid && S_AXI_RREADY_IN) begin
         s_next.rvalid = 1'b0;
         s_next.ar_rdy = 1'b1;
      end

      // Routing always follows the stored selects, so a write shows one cycle later.
      s_next.pin_out = '0;
      s_next.pin_oe  = '0;

      // Timer compare drives its own pin; capture reads it or its neighbour.
      for (int i = 0; i < TMR_PINS; i++) begin
         s_next.pin_out[TMR_CMP_PIN[i]] = TMR_CMP_IN[i];
         s_next.pin_oe[TMR_CMP_PIN[i]]  = TMR_CMP_OE_IN[i];
         if (s_reg.tmr_sel[i]) begin
            s_next.cap[i] = pin_sync.clean[TMR_CAP_PIN[i]];
         end else begin
            s_next.cap[i] = pin_sync.clean[TMR_CMP_PIN[i]];
         end
      end

      // DMA groups come after the timer so a selected group owns shared pins.
      for (int c = 0; c < DMA_CHANS; c++) begin
         code   = s_reg.dma_sel[c*DMA_FIELD_W +: DMA_FIELD_W];
         routed = 1'b0;
         base   = 0;
         if (code == DMA_CODE_A && DMA_GRP_A_OK[c]) begin
            routed = 1'b1;
            base   = DMA_GRP_A_PIN[c];
         end else if (code == DMA_CODE_B) begin
            routed = 1'b1;
            base   = DMA_GRP_B_PIN[c];
         end
         // Prohibited codes leave the channel detached with its request idle.
         if (routed) begin
            s_next.req_n[c] = pin_sync.clean[base + DMA_REQ_OFS];
            s_next.pin_oe[base + DMA_REQ_OFS]   = 1'b0;
            s_next.pin_out[base + DMA_REQ_OFS]  = 1'b0;
            s_next.pin_oe[base + DMA_ACK_OFS]   = 1'b1;
            s_next.pin_out[base + DMA_ACK_OFS]  = DMA_ACK_N_IN[c];
            s_next.pin_oe[base + DMA_TRANSFER_END_OFS]  = 1'b1;
            s_next.pin_out[base + DMA_TRANSFER_END_OFS] = DMA_TRANSFER_END_N_IN[c];
         end else begin
            s_next.req_n[c] = 1'b1;
         end
      end
   end

   // All state apart from the pin synchroniser, including every output, sits in this one register.
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         s_reg <= ST_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs are plain flip-flop taps.
   assign S_AXI_AWREADY_OUT = s_reg.aw_rdy;
   assign S_AXI_WREADY_OUT  = s_reg.w_rdy;
   assign S_AXI_BVALID_OUT  = s_reg.bvalid;
   assign S_AXI_BRESP_OUT   = s_reg.bresp;
   assign S_AXI_ARREADY_OUT = s_reg.ar_rdy;
   assign S_AXI_RVALID_OUT  = s_reg.rvalid;
   assign S_AXI_RRESP_OUT   = s_reg.rresp;
   assign S_AXI_RDATA_OUT   = {24'h00_0000, s_reg.rdata};
   assign PIN_DATA_OUT      = s_reg.pin_out;
   assign PIN_OE_OUT        = s_reg.pin_oe;
   assign DMA_REQ_N_OUT     = s_reg.req_n;
   assign TMR_CAP_OUT       = s_reg.cap;

   // Checks on routing and register access against the stored selects, one cycle late as registered.
   default clocking dtps_cb @(posedge REF_CLK_IN);
   endclocking
   // Reset is released on a clock edge, so checks wait for one routed edge before they start.
   default disable iff (!RSTN_IN || !s_reg.armed);

   AST_DMA_UNROUTED_IDLE: assert property (
      (s_reg.dma_sel[7:6] != DMA_CODE_B) |=> DMA_REQ_N_OUT[3])
      else $error("Channel 3 request not idle while detached.");

   AST_DMA3_GRP_B: assert property (
      (s_reg.dma_sel[7:6] == DMA_CODE_B)
      |=> PIN_OE_OUT[DMA_GRP_B_PIN[3] + DMA_TRANSFER_END_OFS]
          && PIN_DATA_OUT[DMA_GRP_B_PIN[3] + DMA_TRANSFER_END_OFS] == $past(DMA_TRANSFER_END_N_IN[3]))
      else $error("Channel 3 end pin not driven on P65.");

   AST_DMA2_GRP_B: assert property (
      (s_reg.dma_sel[5:4] == DMA_CODE_B)
      |=> DMA_REQ_N_OUT[2] == $past(pin_sync.clean[DMA_GRP_B_PIN[2]]))
      else $error("Channel 2 request not taken from P60.");

   AST_DMA1_GRP_A: assert property (
      (s_reg.dma_sel[3:2] == DMA_CODE_A)
      |=> PIN_OE_OUT[DMA_GRP_A_PIN[1] + DMA_ACK_OFS]
          && PIN_DATA_OUT[DMA_GRP_A_PIN[1] + DMA_ACK_OFS] == $past(DMA_ACK_N_IN[1]))
      else $error("Channel 1 acknowledge not driven on P15.");

   AST_DMA1_GRP_B: assert property (
      (s_reg.dma_sel[3:2] == DMA_CODE_B)
      |=> DMA_REQ_N_OUT[1] == $past(pin_sync.clean[DMA_GRP_B_PIN[1]])
          && !PIN_OE_OUT[DMA_GRP_B_PIN[1]])
      else $error("Channel 1 request not taken from P33.");

   AST_DMA0_GRP_A: assert property (
      (s_reg.dma_sel[1:0] == DMA_CODE_A)
      |=> DMA_REQ_N_OUT[0] == $past(pin_sync.clean[DMA_GRP_A_PIN[0]]))
      else $error("Channel 0 request not taken from P10.");

   AST_DMA0_GRP_B: assert property (
      (s_reg.dma_sel[1:0] == DMA_CODE_B)
      |=> PIN_OE_OUT[DMA_GRP_B_PIN[0] + DMA_TRANSFER_END_OFS]
          && PIN_DATA_OUT[DMA_GRP_B_PIN[0] + DMA_TRANSFER_END_OFS] == $past(DMA_TRANSFER_END_N_IN[0]))
      else $error("Channel 0 end pin not driven on P32.");

   AST_TMR5A: assert property (
      s_reg.tmr_sel[7] |=> TMR_CAP_OUT[7] == $past(pin_sync.clean[TMR_CAP_PIN[7]])
                           && PIN_OE_OUT[TMR_CMP_PIN[7]] == $past(TMR_CMP_OE_IN[7]))
      else $error("Timer 5 pin A split capture wrong.");

   AST_TMR4A: assert property (
      !s_reg.tmr_sel[6] |=> TMR_CAP_OUT[6] == $past(pin_sync.clean[TMR_CMP_PIN[6]])
                            && PIN_DATA_OUT[TMR_CMP_PIN[6]] == $past(TMR_CMP_IN[6]))
      else $error("Timer 4 pin A shared pin wrong.");

   AST_TMR3A: assert property (
      s_reg.tmr_sel[5] |=> TMR_CAP_OUT[5] == $past(pin_sync.clean[TMR_CAP_PIN[5]]))
      else $error("Timer 3 pin A capture not from P20.");

   AST_TMR3C: assert property (
      !s_reg.tmr_sel[4] |=> TMR_CAP_OUT[4] == $past(pin_sync.clean[TMR_CMP_PIN[4]]))
      else $error("Timer 3 pin C capture not from P22.");

   AST_TMR2A: assert property (
      s_reg.tmr_sel[3] |=> TMR_CAP_OUT[3] == $past(pin_sync.clean[TMR_CAP_PIN[3]]))
      else $error("Timer 2 pin A capture not from P37.");

   AST_TMR1A: assert property (
      !s_reg.tmr_sel[2] |=> TMR_CAP_OUT[2] == $past(pin_sync.clean[TMR_CMP_PIN[2]]))
      else $error("Timer 1 pin A capture not from P34.");

   AST_TMR0A: assert property (
      s_reg.tmr_sel[1] |=> TMR_CAP_OUT[1] == $past(pin_sync.clean[TMR_CAP_PIN[1]]))
      else $error("Timer 0 pin A capture not from P31.");

   AST_TMR0C: assert property (
      !s_reg.tmr_sel[0] |=> TMR_CAP_OUT[0] == $past(pin_sync.clean[TMR_CMP_PIN[0]]))
      else $error("Timer 0 pin C capture not from P32.");

   AST_WRITE_APPLIES: assert property (
      (s_reg.aw_got && s_reg.w_got && s_reg.wstrb0
       && s_reg.waddr[ADDR_W-1:2] == OFF_TMR_SEL[ADDR_W-1:2])
      |=> S_AXI_BVALID_OUT && s_reg.tmr_sel == $past(s_reg.wdata)
          ##1 TMR_CAP_OUT[7] == $past(pin_sync.clean[s_reg.tmr_sel[7] ?
                                      TMR_CAP_PIN[7] : TMR_CMP_PIN[7]]))
      else $error("Timer select write not applied on time.");

   AST_DMA3_REQ: assert property (
      (s_reg.dma_sel[7:6] == DMA_CODE_B)
      |=> DMA_REQ_N_OUT[3] == $past(pin_sync.clean[DMA_GRP_B_PIN[3] + DMA_REQ_OFS])
          && !PIN_OE_OUT[DMA_GRP_B_PIN[3] + DMA_REQ_OFS])
      else $error("Channel 3 request not taken from P63.");

   AST_DMA2_ACK: assert property (
      (s_reg.dma_sel[5:4] == DMA_CODE_B)
      |=> PIN_OE_OUT[DMA_GRP_B_PIN[2] + DMA_ACK_OFS]
          && PIN_DATA_OUT[DMA_GRP_B_PIN[2] + DMA_ACK_OFS] == $past(DMA_ACK_N_IN[2]))
      else $error("Channel 2 acknowledge not driven on P61.");

   AST_DMA2_DETACHED: assert property (
      (s_reg.dma_sel[5:4] != DMA_CODE_B)
      |=> DMA_REQ_N_OUT[2] && !PIN_OE_OUT[DMA_GRP_B_PIN[2] + DMA_ACK_OFS])
      else $error("Detached channel 2 still drives or requests.");

   AST_TMR3A_SHARED: assert property (
      !s_reg.tmr_sel[5] |=> TMR_CAP_OUT[5] == $past(pin_sync.clean[TMR_CMP_PIN[5]]))
      else $error("Timer 3 pin A capture not from P21.");

   AST_TMR0C_SPLIT: assert property (
      s_reg.tmr_sel[0] |=> TMR_CAP_OUT[0] == $past(pin_sync.clean[TMR_CAP_PIN[0]]))
      else $error("Timer 0 pin C capture not from P33.");

   AST_READ_DMA_SEL: assert property (
      (S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN
       && S_AXI_ARADDR_IN[ADDR_W-1:2] == OFF_DMA_SEL[ADDR_W-1:2])
      |=> S_AXI_RVALID_OUT && S_AXI_RDATA_OUT == {24'h00_0000, $past(s_reg.dma_sel)})
      else $error("DMA select read back wrong.");

   // Main scenarios worth seeing at least once.
   COV_WRITE: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
   COV_READ: cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
   COV_DMA0_B: cover property (s_reg.dma_sel[1:0] == DMA_CODE_B ##1 !DMA_REQ_N_OUT[0]);
   COV_TMR_SPLIT: cover property (s_reg.tmr_sel == 8'hff);

endmodule : dtps_pin_select

// ===== bench/dtps_pin_select_test.sv
// Self-checking bench for the DMA and timer pin select block.
module dtps_pin_select_test import dtps_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [11:0]       awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb, ack_n, transfer_end_n, req_n;
   logic [1:0]        bresp, rresp, rsp;
   logic [PIN_W-1:0]  pin_in, pin_out, pin_oe;
   logic [7:0]        cmp, cmp_oe, cap;
   logic [31:0]       d;
   int                n_fail = 0;
   int                compares = 0;
   // Compare pin and split capture pin of each timer select bit, bit 0 first.
   int                cmp_p [8] = '{26, 24, 28, 30, 18, 17, 21, 22};
   int                cap_p [8] = '{27, 25, 29, 31, 19, 16, 20, 23};

   dtps_pin_select uut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .S_AXI_AWADDR_IN(awaddr),
      .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
      .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
      .S_AXI_RREADY_IN(rready), .PIN_IN(pin_in), .PIN_DATA_OUT(pin_out), .PIN_OE_OUT(pin_oe),
      .DMA_REQ_N_OUT(req_n), .DMA_ACK_N_IN(ack_n), .DMA_TRANSFER_END_N_IN(transfer_end_n), .TMR_CMP_IN(cmp),
      .TMR_CMP_OE_IN(cmp_oe), .TMR_CAP_OUT(cap));

   // Free-running 125 MHz clock.
   always #4 clk = ~clk;

   // Prints the counts and the verdict, then stops the run.
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   // Write cycle: address and data offered together, each released once taken.
   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, v};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (n < 200) begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (bvalid !== 1'b1) n_fail++;
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   // Read cycle: data and response are taken at the edge that shows rvalid.
   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (n < 200) begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (rvalid !== 1'b1) n_fail++;
      d = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd

   // One DMA channel on group base b: acknowledge and end driven out, request read in.
   task automatic dchk(input int c, input int b);
      logic [3:0] pat;
      for (int p = 0; p < 2; p++) begin
         pat = (p == 0) ? 4'h5 : 4'ha;
         ack_n  <= pat;
         transfer_end_n <= ~pat;
         wt(2);
         chk(pin_out[b+1 +: 2], {~pat[c], pat[c]});
         chk(pin_oe[b +: 3], 32'h6);
      end
      pin_in <= ~(56'h1 << b);
      wt(10);
      chk(req_n[c], 32'h0);
      pin_in <= '1;
      wt(10);
      chk(req_n[c], 32'h1);
   endtask : dchk

   // Main sequence; the synchroniser resets to ones, so idle pads sit high.
   initial begin
      {clk, rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, ack_n, transfer_end_n, cmp, cmp_oe} = '0;
      pin_in = '1;
      wt(12);
      rstn <= 1'b1;
      rd(OFF_DMA_SEL[11:0]);
      chk(d, 32'h0);
      chk(rsp, RESP_OKAY);
      rd(OFF_TMR_SEL[11:0]);
      chk(d, 32'h0);
      chk(req_n[3:2], 32'h3);
      dchk(0, 8);
      dchk(1, 12);
      wr(OFF_DMA_SEL[11:0], 8'h55, 4'hf);
      @(negedge clk);
      chk(pin_oe[26:24], 32'h6);
      chk(pin_oe[9], 32'h0);
      rd(OFF_DMA_SEL[11:0]);
      chk(d, 32'h55);
      dchk(0, 24);
      dchk(1, 27);
      dchk(2, 48);
      dchk(3, 51);
      // Only legal codes are written; a write without lane 0 leaves the select alone.
      wr(OFF_DMA_SEL[11:0], 8'h50, 4'hf);
      wr(OFF_DMA_SEL[11:0], 8'h55, 4'h0);
      chk(rsp, RESP_OKAY);
      rd(OFF_DMA_SEL[11:0]);
      chk(d, 32'h50);
      wr(12'h008, 8'h11, 4'hf);
      chk(rsp, RESP_SLVERR);
      rd(12'h008);
      chk(d, 32'h0);
      chk(rsp, RESP_SLVERR);
      // Each timer bit cleared and then set: capture source moves, compare drive stays.
      cmp    <= 8'h5a;
      cmp_oe <= 8'hff;
      for (int s = 0; s < 2; s++) begin
         wr(OFF_TMR_SEL[11:0], s ? 8'hff : 8'h00, 4'hf);
         rd(OFF_TMR_SEL[11:0]);
         chk(d, s ? 32'hff : 32'h0);
         for (int i = 0; i < 8; i++) begin
            pin_in <= ~(56'h1 << cmp_p[i]);
            wt(10);
            chk(cap[i], s);
            pin_in <= ~(56'h1 << cap_p[i]);
            wt(10);
            chk(cap[i], 1 - s);
            chk({pin_oe[cmp_p[i]], pin_out[cmp_p[i]]}, {1'b1, cmp[i]});
         end
      end
      close_out();
   end

   // Watchdog set well beyond the several hundred cycles the sequence needs.
   initial begin
      #400000;
      n_fail++;
      close_out();
   end
endmodule : dtps_pin_select_test
